// >>> include/tap_pkg.sv
package tap_pkg;

	// Controller states, standard encoding
	typedef enum logic [3:0] {
		ST_RESET = 4'hf,
		ST_IDLE = 4'hc,
		ST_SEL_DR = 4'h7,
		ST_CAP_DR = 4'h6,
		ST_SHIFT_DR = 4'h2,
		ST_EXIT1_DR = 4'h1,
		ST_PAUSE_DR = 4'h3,
		ST_EXIT2_DR = 4'h0,
		ST_UPD_DR = 4'h5,
		ST_SEL_IR = 4'h4,
		ST_CAP_IR = 4'he,
		ST_SHIFT_IR = 4'ha,
		ST_EXIT1_IR = 4'h9,
		ST_PAUSE_IR = 4'hb,
		ST_EXIT2_IR = 4'h8,
		ST_UPD_IR = 4'hd
	} tap_state_t;

	localparam int IR_W = 4;
	// Instruction reset value selects bypass
	localparam logic [IR_W-1:0] IR_RESET = 4'hf;
	// Fixed capture pattern, low two bits 01
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
	localparam int ID_W = 32;
	// Identification value is arbitrary
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h00000001;
	localparam int SYNC_STAGES = 2;

endpackage

// >>> core/sync_2ff.sv
`timescale 1ns/1ps
// Two flop synchroniser for one pin level
module sync_2ff (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_r;

	// Only the second stage is read downstream
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // sync_2ff

// >>> core/boundary_scan_test_port.sv
`timescale 1ns/1ps
module boundary_scan_test_port
	import tap_pkg::*;
#(
	parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Test pins from the controller
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	// Test data out, tri-state as value plus enable
	output logic tdo,
	output logic tdo_oe,
	// Controller state for observation
	output logic [3:0] tap_state
);
	// Synchronised pin levels
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_n_s;
	// Test clock edge finder
	logic tck_d_r;
	logic rise;
	logic fall;
	// Controller state
	tap_state_t st_r;
	tap_state_t st_nxt;
	// Instruction shift and hold stages
	logic [IR_W-1:0] ir_sh_r;
	logic [IR_W-1:0] ir_r;
	// Data registers and the bit they offer
	logic bypass_r;
	logic [ID_W-1:0] id_sh_r;
	logic shift_bit;

	// All pins cross from the tester clock domain. The cost is two
	// system clocks of latency on every pin, so each test clock phase
	// must last longer than one system clock or an edge is lost; test
	// reset goes through the same two stages as the other pins.
	sync_2ff u_sync_tck (.clk(clk), .rst(rst), .d(tck), .q(tck_s));
	sync_2ff u_sync_tms (.clk(clk), .rst(rst), .d(tms), .q(tms_s));
	sync_2ff u_sync_tdi (.clk(clk), .rst(rst), .d(tdi), .q(tdi_s));
	sync_2ff u_sync_trst (.clk(clk), .rst(rst), .d(trst_n), .q(trst_n_s));

	// Edge finder on the synchronised test clock. It resets to the idle
	// low level of the pin, so no false rising edge follows a reset, and
	// it reads only the second synchroniser stage.
	always_ff @(posedge clk) begin
		if (rst)
			tck_d_r <= 1'b0;
		else
			tck_d_r <= tck_s;
	end

	// No edge means no state change unless test reset is low, so an idle clock holds all
	assign rise = tck_s & ~tck_d_r;
	assign fall = ~tck_s & tck_d_r;

	// Next state from mode select, taken at each rising edge. Every state
	// has a defined exit, so five rises with mode select high always
	// reach the reset state from anywhere.
	always_comb begin
		case (st_r)
			// Reset and idle
			ST_RESET: begin
				st_nxt = tms_s ? ST_RESET : ST_IDLE;
			end
			ST_IDLE: begin
				st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
			end
			// Data register column
			ST_SEL_DR: begin
				st_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
			end
			ST_CAP_DR: begin
				st_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			end
			ST_SHIFT_DR: begin
				st_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			end
			ST_EXIT1_DR: begin
				st_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
			end
			ST_PAUSE_DR: begin
				st_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
			end
			ST_EXIT2_DR: begin
				st_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
			end
			ST_UPD_DR: begin
				st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
			end
			// Instruction register column
			ST_SEL_IR: begin
				st_nxt = tms_s ? ST_RESET : ST_CAP_IR;
			end
			ST_CAP_IR: begin
				st_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			end
			ST_SHIFT_IR: begin
				st_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			end
			ST_EXIT1_IR: begin
				st_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
			end
			ST_PAUSE_IR: begin
				st_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
			end
			ST_EXIT2_IR: begin
				st_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
			end
			ST_UPD_IR: begin
				st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
			end
			// Unused codes cannot occur; fall back to reset
			default: begin
				st_nxt = ST_RESET;
			end
		endcase
	end

	// State register; test reset wins without waiting for a tck edge.
	// Without a rising edge nothing moves, which is what keeps all test
	// state frozen while the test clock idles low.
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s)
			st_r <= ST_RESET;
		else if (rise)
			st_r <= st_nxt;
	end

	// Instruction shift and update stages. The held stage only moves in
	// update or reset, so a half-shifted instruction never takes effect
	// while the new bits are still on their way in.
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s) begin
			ir_sh_r <= IR_RESET;
			ir_r <= IR_RESET;
		end else if (rise) begin
			case (st_r)
				ST_RESET: ir_r <= IR_RESET;
				ST_CAP_IR: ir_sh_r <= IR_CAPTURE;
				ST_SHIFT_IR: ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
				ST_UPD_IR: ir_r <= ir_sh_r;
				default: ir_sh_r <= ir_sh_r;
			endcase
		end
	end

	// Bypass: one stage that captures zero
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s)
			bypass_r <= 1'b0;
		else if (rise && st_r == ST_CAP_DR)
			bypass_r <= 1'b0;
		else if (rise && st_r == ST_SHIFT_DR)
			bypass_r <= tdi_s;
	end

	// Identification: loads the fixed value, then shifts LSB first
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s)
			id_sh_r <= '0;
		else if (rise && st_r == ST_CAP_DR)
			id_sh_r <= ID_VALUE;
		else if (rise && st_r == ST_SHIFT_DR)
			id_sh_r <= {tdi_s, id_sh_r[ID_W-1:1]};
	end

	// Bit that leaves the chain on the next falling edge; every opcode
	// other than identification falls back to the bypass stage
	always_comb begin
		if (st_r == ST_SHIFT_IR)
			shift_bit = ir_sh_r[0];
		else if (ir_r == OP_IDCODE)
			shift_bit = id_sh_r[0];
		else
			shift_bit = bypass_r;
	end

	// Output retimed on falling edges only, so the tester samples a
	// stable bit at its next rising edge
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s)
			tdo <= 1'b0;
		else if (fall)
			tdo <= shift_bit;
	end

	// Driver enable follows the shift states; it also moves on a fall,
	// so the pin never floats in the middle of a bit
	always_ff @(posedge clk) begin
		if (rst || !trst_n_s)
			tdo_oe <= 1'b0;
		else if (fall)
			tdo_oe <= (st_r == ST_SHIFT_DR) || (st_r == ST_SHIFT_IR);
	end

	// Observed copy of the state. It lags the controller by one system
	// clock, which an observer must allow for; it is not used inside the
	// port, so the lag costs nothing in the scan itself.
	always_ff @(posedge clk) begin
		if (rst)
			tap_state <= 4'hf;
		else
			tap_state <= st_r;
	end
endmodule // boundary_scan_test_port

// >>> tb/tap_port_properties.sv
`timescale 1ns/1ps
module tap_port_properties
	import tap_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Test pins and outputs
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [3:0] tap_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Long enough low phase to cover the synchroniser delay
	sequence idle_low;
		(!tck && trst_n) [*6];
	endsequence
	AST_OE_SHIFT: assert property ($rose(tdo_oe) |->
		tap_state == ST_SHIFT_DR || tap_state == ST_SHIFT_IR)
		else $error("driver enabled outside a shift state");
	AST_TRST: assert property (!trst_n [*5] |->
		tap_state == ST_RESET && !tdo_oe)
		else $error("test reset did not reset the port");
	AST_HOLD: assert property (idle_low |->
		$stable(tap_state) && $stable(tdo))
		else $error("state moved while test clock idle");
	AST_TDO_FALL: assert property ($changed(tdo) && tdo_oe |->
		!$past(tck, 2))
		else $error("data out changed after a rising edge");
	AST_STEP_RISE: assert property ($changed(tap_state) && trst_n |->
		$past(tck, 2))
		else $error("state changed without a rising edge");
	AST_IDLE_OE: assert property (tap_state == ST_IDLE |->
		!tdo_oe)
		else $error("driver enabled in the idle state");
endmodule // tap_port_properties
bind boundary_scan_test_port tap_port_properties tap_port_properties_i(
	.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
	.trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .tap_state(tap_state));

// >>> tb/tap_ctrl_model.sv
`timescale 1ns/1ps
module tap_ctrl_model (
	// System clock paces the test clock
	input wire logic clk,
	// Returned data
	input wire logic tdo,
	input wire logic tdo_oe,
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n
);
	// Test clock idles low between steps
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
	end
	// One 80 ns test clock period; data out is read at the rise
	task automatic step(input logic m, input logic d, output logic q,
		output logic e);
		@(posedge clk) begin
			tms <= m;
			tdi <= d;
		end
		repeat (3) @(posedge clk);
		q = tdo;
		e = tdo_oe;
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		tck <= 1'b0;
	endtask
	// Test reset pin, changed just after an edge
	task automatic set_reset(input logic v);
		@(posedge clk) trst_n <= v;
	endtask
endmodule // tap_ctrl_model

// >>> tb/boundary_scan_test_port_tb.sv
`timescale 1ns/1ps
`define chk(n, x, g) num_checks++; if ((g) !== (x)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, x, g); end
module boundary_scan_test_port_tb;
	import tap_pkg::*;
	logic clk = 1'b0, rst = 1'b1, tck, tms, tdi, trst_n, tdo, tdo_oe, q, e;
	logic [3:0] tap_state;
	logic [31:0] got;
	int failures = 0, num_checks = 0, cycles = 0;
	boundary_scan_test_port boundary_scan_test_port_i(.clk(clk), .rst(rst),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .tap_state(tap_state));
	tap_ctrl_model tap_ctrl_model_i(.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
	// Clock and a hang guard well above the 610 cycles needed
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic go(input logic [7:0] s, input int n);
		for (int i = 0; i < n; i++) tap_ctrl_model_i.step(s[i], 1'b1, q, e);
	endtask
	// Last bit leaves the shift state, as the protocol requires
	task automatic shift(input logic [31:0] v, input int n);
		got = '0;
		for (int i = 0; i < n; i++) begin
			tap_ctrl_model_i.step(i == n - 1, v[i], q, e);
			got[i] = q;
			`chk("oe", 1'b1, e)
		end
	endtask
	task automatic load_ir(input logic [IR_W-1:0] op);
		go(8'h06, 5);
		shift(32'(op), IR_W);
		`chk("ir capture", IR_CAPTURE, got[IR_W-1:0])
		go(8'h01, 2);
		@(posedge clk);
		`chk("state", ST_IDLE, tap_state)
		$display("instruction loaded");
	endtask
	task automatic test_idcode();
		load_ir(OP_IDCODE);
		go(8'h00, 1);
		`chk("oe idle", 1'b0, e)
		go(8'h01, 3);
		shift(32'h0, ID_W);
		`chk("id", ID_DEFAULT, got)
		go(8'h01, 2);
		$display("identification done");
	endtask
	task automatic test_bypass();
		load_ir(OP_BYPASS);
		go(8'h01, 3);
		shift(32'h16, 5);
		`chk("bypass", 5'h0c, got[4:0])
		go(8'h01, 2);
		$display("bypass done");
	endtask
	// Reset mid-scan with the test clock stopped
	task automatic test_trst();
		go(8'h01, 3);
		tap_ctrl_model_i.set_reset(1'b0);
		repeat (6) @(posedge clk);
		`chk("state", ST_RESET, tap_state)
		`chk("oe", 1'b0, tdo_oe)
		tap_ctrl_model_i.set_reset(1'b1);
		repeat (10) @(posedge clk);
		`chk("state held", ST_RESET, tap_state)
		$display("test reset done");
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_idcode();
		test_bypass();
		test_trst();
		print_verdict();
	end
endmodule // boundary_scan_test_port_tb
